// file: design/pit_idle_timers.sv
// Peripheral idle timers and I/O traps with an AHB-Lite register slave
//
// Function
// R01: I/O cycles compare 16 address bits; memory cycles are never decoded.
// R02: Each idle timer is a 16-bit down counter ticking once per second.
// R03: Enabling loads the timer; first following tick never signals expiry.
// R04: Loaded with 1: reaches 0 silently, then wraps to 65535.
// R05: Loaded with 2: steps 1, then 0 with expiry.
// R06: Access to a running timer's range reloads its starting value.
// R07: Expiry raises SMI only with global power management set.
// R08: Setting a per-device enable bit reloads the timer.
// R09: Global idle enable gates timers; clearing freezes, setting resumes without reload.
// R10: Global trap enable gates both device I/O traps.
// R11: Global idle enable needed for the software CPU suspend command.
// R12: Power management off ignores suspend command and suppresses SMI triggers.
// R13: Keyboard/mouse timer enabled by bit 3, reloaded by ports 060h/064h.
// R14: Keyboard/mouse decode adds first or second serial port by placement field.
// R15: Keyboard/mouse trap raises SMI, status in trap status bit 3.
// R16: Mouse serial port leaves parallel/serial monitoring, joins keyboard decode.
// R17: Mouse select 0 picks first serial port, 1 the second.
// R18: Keyboard/mouse expiry recorded in timer status bit 3, summary bit 0.
// R19: Parallel/serial timer enabled by bit 2, reloaded by port accesses.
// R20: Parallel/serial trap enabled by bit 2, status in trap status bit 2.
// R21: Parallel/serial count is 16-bit seconds; mouse serial port excluded.
// R22: One shared single-cycle one-second tick drives all timers.
// R23: Software swaps timer and trap around peripheral power down and up.
`timescale 1ns/1ps
`include "pit_params.svh"

module pit_idle_timers
  import pit_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `PIT_TICK_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        bus_cyc,
  input  wire logic        bus_is_io,
  input  wire logic [31:0] bus_addr,
  output logic             smi,
  output logic             cpu_suspend_handshake
);

  localparam logic [27:0] TICK_LAST = 28'(TICK_CYCLES - 1);

  pit_state_t s_r;
  pit_state_t s_nxt;

  logic       io_cyc;
  logic       kbd_port;
  logic       ser1_hit;
  logic       ser2_hit;
  logic       par_hit;
  logic       mouse_ser1;
  logic       mouse_ser2;
  logic [1:0] dev_hit;
  logic [1:0] dev_bit_en;
  logic [1:0][15:0] dev_start;
  logic       a_take;
  logic [31:0] rd_word;
  logic       sts_any;

  // R01 I/O decode uses only 16 address bits, and only on I/O cycles
  assign io_cyc     = bus_cyc & bus_is_io;
  // R13 keyboard controller ports
  assign kbd_port   = (bus_addr[15:0] == `PIT_KBD_DATA) | (bus_addr[15:0] == `PIT_KBD_CMD);
  assign ser1_hit   = (bus_addr[15:0] & `PIT_RANGE_MASK) == `PIT_SER1_BASE;
  assign ser2_hit   = (bus_addr[15:0] & `PIT_RANGE_MASK) == `PIT_SER2_BASE;
  assign par_hit    = ((bus_addr[15:0] & `PIT_RANGE_MASK) == `PIT_PAR1_BASE)
                    | ((bus_addr[15:0] & `PIT_RANGE_MASK) == `PIT_PAR2_BASE);
  // R17 select bit chooses the serial port carrying the mouse
  assign mouse_ser1 = s_r.misc[`PIT_MISC_ON_SER] & ~s_r.misc[`PIT_MISC_SEL];
  assign mouse_ser2 = s_r.misc[`PIT_MISC_ON_SER] &  s_r.misc[`PIT_MISC_SEL];
  // R14 keyboard decode adds the mouse serial port
  assign dev_hit[1] = io_cyc & (kbd_port | (ser1_hit & mouse_ser1) | (ser2_hit & mouse_ser2));
  // R16 R19 R21 parallel/serial decode drops the mouse serial port
  assign dev_hit[0] = io_cyc & (par_hit | (ser1_hit & ~mouse_ser1) | (ser2_hit & ~mouse_ser2));
  assign dev_bit_en = {s_r.tmr_en[`PIT_DEV_KBD], s_r.tmr_en[`PIT_DEV_PS]};
  assign dev_start  = {s_r.kbd_cnt, s_r.ps_cnt};
  assign sts_any    = (|s_r.tmr_sts) | (|s_r.trap_sts);

  assign a_take = hsel & htrans[1] & hready;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (haddr[31:10] == 22'h0) begin
      case (haddr[9:2])
        `PIT_IDX_GLOBAL:   rd_word = {24'h000000, s_r.glb};
        `PIT_IDX_TMR_EN:   rd_word = {24'h000000, s_r.tmr_en};
        `PIT_IDX_TRAP_EN:  rd_word = {24'h000000, s_r.trap_en};
        `PIT_IDX_TMR_STS:  rd_word = {24'h000000, s_r.tmr_sts};
        `PIT_IDX_TRAP_STS: rd_word = {24'h000000, s_r.trap_sts};
        `PIT_IDX_MISC:     rd_word = {24'h000000, s_r.misc};
        `PIT_IDX_PS_CNT:   rd_word = {16'h0000, s_r.ps_cnt};
        `PIT_IDX_KBD_CNT:  rd_word = {16'h0000, s_r.kbd_cnt};
        `PIT_IDX_SUMMARY:  rd_word = {31'h00000000, sts_any};
        default:           rd_word = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    logic       wr;
    logic [1:0] run;
    logic [1:0] load;
    logic [7:0] tmr_set;
    logic [7:0] trap_set;
    logic [15:0] dec;
    wr       = 1'b0;
    run      = 2'b00;
    load     = 2'b00;
    tmr_set  = 8'h00;
    trap_set = 8'h00;
    dec      = 16'h0000;
    s_nxt    = s_r;

    // R22 one shared one-second tick for all timers
    s_nxt.tick = 1'b0;
    if (s_r.pres == TICK_LAST) begin
      s_nxt.pres = 28'h0000000;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.pres = s_r.pres + 28'h0000001;
    end

    // Zero-wait slave: read data is registered from the address phase
    s_nxt.hready = 1'b1;
    s_nxt.a_sel  = a_take;
    s_nxt.a_wr   = hwrite;
    s_nxt.a_idx  = (haddr[31:10] == 22'h0) ? haddr[9:2] : 8'h00;
    if (a_take & ~hwrite) begin
      s_nxt.hrdata = rd_word;
    end
    wr = s_r.a_sel & s_r.a_wr;

    if (wr) begin
      case (s_r.a_idx)
        `PIT_IDX_GLOBAL:  s_nxt.glb     = hwdata[7:0];
        `PIT_IDX_TMR_EN:  s_nxt.tmr_en  = hwdata[7:0];
        `PIT_IDX_TRAP_EN: s_nxt.trap_en = hwdata[7:0];
        `PIT_IDX_MISC:    s_nxt.misc    = hwdata[7:0];
        `PIT_IDX_PS_CNT:  s_nxt.ps_cnt  = hwdata[15:0];
        `PIT_IDX_KBD_CNT: s_nxt.kbd_cnt = hwdata[15:0];
        // Status clears by writing ones
        `PIT_IDX_TMR_STS: s_nxt.tmr_sts  = s_r.tmr_sts & ~hwdata[7:0];
        `PIT_IDX_TRAP_STS: s_nxt.trap_sts = s_r.trap_sts & ~hwdata[7:0];
        default: ;
      endcase
    end

    for (int i = 0; i < 2; i++) begin
      // R09 global idle enable gates every timer
      run[i]  = s_r.glb[`PIT_GLB_IDLE] & dev_bit_en[i];
      // R08 enable edge reloads; R06 range hit on running timer reloads
      load[i] = (dev_bit_en[i] & ~s_r.en_q[i]) | (run[i] & dev_hit[i]);
      dec     = s_r.tmr_val[i] - 16'h0001;
      if (load[i]) begin
        // R03 load, first tick cannot expire
        s_nxt.tmr_val[i] = dev_start[i];
        s_nxt.first[i]   = 1'b1;
      end else if (run[i] & s_r.tick) begin
        // R02 R04 decrement with wrap past zero
        s_nxt.tmr_val[i] = dec;
        s_nxt.first[i]   = 1'b0;
        // R05 R07 R12 expiry reported only with power management on
        if ((dec == 16'h0000) & ~s_r.first[i] & s_r.glb[`PIT_GLB_PM]) begin
          tmr_set[`PIT_DEV_PS + i] = 1'b1;
        end
      end
    end
    s_nxt.en_q = dev_bit_en;

    // R10 R12 R15 R20 traps need global trap and power management
    if (s_r.glb[`PIT_GLB_TRAP] & s_r.glb[`PIT_GLB_PM]) begin
      trap_set[`PIT_DEV_KBD] = dev_hit[1] & s_r.trap_en[`PIT_DEV_KBD];
      trap_set[`PIT_DEV_PS]  = dev_hit[0] & s_r.trap_en[`PIT_DEV_PS];
    end
    // R18 hardware set wins over a same-cycle clear
    s_nxt.tmr_sts  = s_nxt.tmr_sts | tmr_set;
    s_nxt.trap_sts = s_nxt.trap_sts | trap_set;

    // R12 SMI is suppressed while power management is off
    s_nxt.smi = s_r.glb[`PIT_GLB_PM] & sts_any;

    // R11 R12 suspend command needs both enables and no pending status
    s_nxt.susp = wr & (s_r.a_idx == `PIT_IDX_SUSP_CMD) & s_r.glb[`PIT_GLB_PM]
               & s_r.glb[`PIT_GLB_IDLE] & ~sts_any;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout             = s_r.hready;
  assign hrdata                = s_r.hrdata;
  assign hresp                 = 1'b0;
  assign smi                   = s_r.smi;
  assign cpu_suspend_handshake = s_r.susp;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence kbd_run_hit_s;
    s_r.glb[`PIT_GLB_IDLE] && s_r.tmr_en[`PIT_DEV_KBD] && s_r.en_q[1] && dev_hit[1];
  endsequence

  sequence ps_tick_run_s;
    s_r.tick && s_r.glb[`PIT_GLB_IDLE] && s_r.tmr_en[`PIT_DEV_PS] && s_r.en_q[0] && !dev_hit[0];
  endsequence

  // R06 R13 access reloads keyboard timer
  kbd_reload_a: assert property (kbd_run_hit_s |=> s_r.tmr_val[1] == $past(s_r.kbd_cnt) && s_r.first[1]) // R06
    else $error("keyboard timer not reloaded on access");

  // R02 tick decrements by one
  ps_decrement_a: assert property (ps_tick_run_s |=> s_r.tmr_val[0] == $past(s_r.tmr_val[0]) - 16'h0001) // R02
    else $error("parallel timer did not decrement");

  // R09 frozen while globally disabled
  idle_freeze_a: assert property (!s_r.glb[`PIT_GLB_IDLE] && s_r.en_q == dev_bit_en // R09
    |=> $stable(s_r.tmr_val))
    else $error("timer moved while idle timers disabled");

  // R03 first tick never expires
  first_quiet_a: assert property (ps_tick_run_s and s_r.first[0] |=> !s_r.tmr_sts[`PIT_DEV_PS] // R03
    || $past(s_r.tmr_sts[`PIT_DEV_PS]))
    else $error("expiry on first tick");

  // R05 expiry sets status
  expiry_set_a: assert property (ps_tick_run_s and !s_r.first[0] && s_r.tmr_val[0] == 16'h0001 // R05
    && s_r.glb[`PIT_GLB_PM] |=> s_r.tmr_sts[`PIT_DEV_PS])
    else $error("expiry status missing");

  // R07 no new status with power management off
  pm_block_a: assert property (!s_r.glb[`PIT_GLB_PM] && !(s_r.a_sel && s_r.a_wr) // R07
    |=> s_r.tmr_sts == $past(s_r.tmr_sts) && s_r.trap_sts == $past(s_r.trap_sts))
    else $error("status set while power management off");

  // R15 keyboard trap sets status
  kbd_trap_a: assert property (dev_hit[1] && s_r.trap_en[`PIT_DEV_KBD] && s_r.glb[`PIT_GLB_TRAP] // R15
    && s_r.glb[`PIT_GLB_PM] |=> s_r.trap_sts[`PIT_DEV_KBD] ##1 smi)
    else $error("keyboard trap missed");

  // R11 suspend only with idle timers enabled
  susp_gate_a: assert property (cpu_suspend_handshake |-> $past(s_r.glb[`PIT_GLB_IDLE]) // R11
    && $past(s_r.glb[`PIT_GLB_PM]))
    else $error("suspend without enables");

  // R16 mouse serial port does not reload parallel timer
  mouse_excl_a: assert property (s_r.misc[`PIT_MISC_ON_SER] && !s_r.misc[`PIT_MISC_SEL] && io_cyc // R16
    && ser1_hit |-> !dev_hit[0] && dev_hit[1])
    else $error("mouse serial port decoded wrongly");

  // R22 tick is a single cycle pulse
  tick_pulse_a: assert property (s_r.tick |=> !s_r.tick) // R22
    else $error("tick longer than one cycle");

  sequence kbd_tick_run_s;
    s_r.tick && s_r.glb[`PIT_GLB_IDLE] && s_r.tmr_en[`PIT_DEV_KBD] && s_r.en_q[1] && !dev_hit[1];
  endsequence

  sequence ps_run_hit_s;
    s_r.glb[`PIT_GLB_IDLE] && s_r.tmr_en[`PIT_DEV_PS] && s_r.en_q[0] && dev_hit[0];
  endsequence

  // R19 R21 access reloads parallel timer
  ps_reload_a: assert property (ps_run_hit_s |=> s_r.tmr_val[0] == $past(s_r.ps_cnt) && s_r.first[0]) // R19
    else $error("parallel timer not reloaded on access");

  // R08 enable edge loads keyboard timer
  kbd_enable_load_a: assert property (s_r.tmr_en[`PIT_DEV_KBD] && !s_r.en_q[1] // R08
    |=> s_r.tmr_val[1] == $past(s_r.kbd_cnt) && s_r.first[1])
    else $error("keyboard timer not loaded on enable");

  // R04 zero wraps to all ones
  ps_wrap_a: assert property (ps_tick_run_s and s_r.tmr_val[0] == 16'h0000 // R04
    |=> s_r.tmr_val[0] == 16'hFFFF)
    else $error("parallel timer did not wrap");

  // R02 keyboard timer decrements by one
  kbd_decrement_a: assert property (kbd_tick_run_s // R02
    |=> s_r.tmr_val[1] == $past(s_r.tmr_val[1]) - 16'h0001)
    else $error("keyboard timer did not decrement");

  // R13 R18 keyboard expiry sets status
  kbd_expiry_a: assert property (kbd_tick_run_s and !s_r.first[1] && s_r.tmr_val[1] == 16'h0001 // R18
    && s_r.glb[`PIT_GLB_PM] |=> s_r.tmr_sts[`PIT_DEV_KBD])
    else $error("keyboard expiry status missing");

  // R12 no SMI without power management
  smi_block_a: assert property (!s_r.glb[`PIT_GLB_PM] |=> !smi) // R12
    else $error("smi raised while power management off");

  // R07 pending status raises SMI
  smi_raise_a: assert property (s_r.glb[`PIT_GLB_PM] && s_r.tmr_sts[`PIT_DEV_KBD] |=> smi) // R07
    else $error("smi missing for pending status");

  // R20 parallel trap sets status
  ps_trap_a: assert property (dev_hit[0] && s_r.trap_en[`PIT_DEV_PS] && s_r.glb[`PIT_GLB_TRAP] // R20
    && s_r.glb[`PIT_GLB_PM] |=> s_r.trap_sts[`PIT_DEV_PS])
    else $error("parallel trap missed");

  // R10 traps off leave status alone
  trap_gate_a: assert property (!s_r.glb[`PIT_GLB_TRAP] && !(s_r.a_sel && s_r.a_wr) // R10
    |=> $stable(s_r.trap_sts))
    else $error("trap status set while traps disabled");

  // R15 disabled keyboard trap stays quiet
  kbd_trap_off_a: assert property (!s_r.trap_en[`PIT_DEV_KBD] && !(s_r.a_sel && s_r.a_wr) // R15
    |=> $stable(s_r.trap_sts[`PIT_DEV_KBD]))
    else $error("keyboard trap status set while disabled");

  // R01 memory cycles never hit
  mem_cycle_a: assert property (bus_cyc && !bus_is_io |-> dev_hit == 2'b00) // R01
    else $error("memory cycle decoded as device access");

  // R14 R17 second serial port joins keyboard decode
  mouse_ser2_a: assert property (s_r.misc[`PIT_MISC_ON_SER] && s_r.misc[`PIT_MISC_SEL] && io_cyc // R17
    && ser2_hit |-> dev_hit[1] && !dev_hit[0])
    else $error("second serial mouse port decoded wrongly");

  // R13 keyboard ports always hit
  kbd_port_a: assert property (io_cyc && kbd_port |-> dev_hit[1]) // R13
    else $error("keyboard port access not decoded");

  // R22 tick lands on prescaler wrap
  tick_align_a: assert property (s_r.tick |-> s_r.pres == 28'h0000000) // R22
    else $error("tick out of step with prescaler");

endmodule // pit_idle_timers

// file: shared/pit_params.svh
// Register map, field positions, decode ranges and timing constants of the idle timer block
`ifndef PIT_PARAMS_SVH
`define PIT_PARAMS_SVH

// Register indices; byte address is four times the index
`define PIT_IDX_GLOBAL     8'h80
`define PIT_IDX_TMR_EN     8'h81
`define PIT_IDX_TRAP_EN    8'h82
`define PIT_IDX_TMR_STS    8'h85
`define PIT_IDX_TRAP_STS   8'h86
`define PIT_IDX_MISC       8'h93
`define PIT_IDX_PS_CNT     8'h9C
`define PIT_IDX_KBD_CNT    8'h9E
`define PIT_IDX_SUMMARY    8'hC8
`define PIT_IDX_SUSP_CMD   8'hAE

// Reset values
`define PIT_RST_BYTE       8'h00
`define PIT_RST_COUNT      16'h0000

// Global enable fields
`define PIT_GLB_PM         0
`define PIT_GLB_IDLE       1
`define PIT_GLB_TRAP       2

// Per-device bits in enables and status registers
`define PIT_DEV_PS         2
`define PIT_DEV_KBD        3

// Mouse placement field
`define PIT_MISC_SEL       0
`define PIT_MISC_ON_SER    1

// Decode ranges, 16-bit I/O addresses
`define PIT_KBD_DATA       16'h0060
`define PIT_KBD_CMD        16'h0064
`define PIT_SER1_BASE      16'h03F8
`define PIT_SER2_BASE      16'h02F8
`define PIT_PAR1_BASE      16'h0378
`define PIT_PAR2_BASE      16'h0278
`define PIT_RANGE_MASK     16'hFFF8

// Timebase
`define PIT_TICK_PERIOD_NS 1000000000
`define PIT_CLK_PERIOD_NS  4
`define PIT_TICK_CYCLES    (`PIT_TICK_PERIOD_NS / `PIT_CLK_PERIOD_NS)

`endif

// file: shared/pit_pkg.sv
// Types of the peripheral idle timer and trap block
package pit_pkg;

  typedef logic [15:0] pit_count_t;

  typedef struct packed {
    logic [7:0]            glb;
    logic [7:0]            tmr_en;
    logic [7:0]            trap_en;
    logic [7:0]            misc;
    pit_count_t            kbd_cnt;
    pit_count_t            ps_cnt;
    logic [7:0]            tmr_sts;
    logic [7:0]            trap_sts;
    logic [1:0][15:0]      tmr_val;
    logic [1:0]            first;
    logic [1:0]            en_q;
    logic [27:0]           pres;
    logic                  tick;
    logic                  a_sel;
    logic                  a_wr;
    logic [7:0]            a_idx;
    logic [31:0]           hrdata;
    logic                  hready;
    logic                  smi;
    logic                  susp;
  } pit_state_t;

endpackage

// file: verif/pit_host_bus_model.sv
// Host bus model: turns bench requests into monitored bus cycles
`timescale 1ns/1ps

module pit_host_bus_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic        go_io,
  input  wire logic [31:0] go_addr,
  output logic             bus_cyc,
  output logic             bus_is_io,
  output logic [31:0]      bus_addr
);
  // Idle lines scramble so a stale address never fakes a hit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_cyc   <= 1'b0;
      bus_is_io <= 1'b0;
      bus_addr  <= 32'h0;
    end else begin
      bus_cyc   <= go;
      bus_is_io <= go ? go_io : ~bus_is_io;
      bus_addr  <= go ? go_addr : ~bus_addr;
    end
  end
endmodule // pit_host_bus_model

// file: verif/test_peripheral_idle_timers_traps.sv
// Self-checking bench of the idle timer and trap block
`timescale 1ns/1ps

module test_peripheral_idle_timers_traps;
  logic        sys_clk = 0;
  logic        rst     = 1;
  logic        hsel    = 0;
  logic        hwrite  = 0;
  logic        go      = 0;
  logic        go_io   = 0;
  logic [1:0]  htrans  = 0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] haddr   = 0;
  logic [31:0] hwdata  = 0;
  logic [31:0] go_addr = 0;
  logic [31:0] q;
  logic [31:0] r;
  logic [31:0] e;
  logic        seen;
  logic        rsp;
  wire logic   hreadyout, hresp, smi, susp, bus_cyc, bus_is_io;
  wire logic [31:0] hrdata, bus_addr;
  int          fails   = 0;
  int          checked = 0;
  int          seed    = 32'h483dfffa;
  int          susp_n  = 0;
  int          k, n0;
  logic [15:0] bases [7] = '{16'h0060, 16'h0064, 16'h0378, 16'h0278, 16'h03F8, 16'h02F8, 16'h0061};

  pit_idle_timers #(.TICK_CYCLES(8)) pit_idle_timers_i (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .bus_cyc(bus_cyc), .bus_is_io(bus_is_io),
    .bus_addr(bus_addr), .smi(smi), .cpu_suspend_handshake(susp));
  pit_host_bus_model pit_host_bus_model_i (.sys_clk(sys_clk), .rst(rst), .go(go), .go_io(go_io),
    .go_addr(go_addr), .bus_cyc(bus_cyc), .bus_is_io(bus_is_io), .bus_addr(bus_addr));

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (susp === 1'b1) susp_n++;
  end

  task automatic test_done;
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      fails++;
      test_done;
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy;
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
    rsp = hresp;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    ahb(0, a, 0);
    chk(q, exp);
    chk(rsp, 32'h0);
  endtask
  task automatic hit(input logic io, input logic [31:0] a);
    go <= 1;
    go_io <= io;
    go_addr <= a;
    @(posedge sys_clk);
    go <= 0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic watch(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      seen = seen | (smi === 1'b1);
    end
  endtask
  task automatic rearm(input logic [31:0] cnt_addr, input logic [31:0] cnt, input logic [7:0] en);
    ahb(1, 32'h204, 0);
    ahb(1, 32'h214, 32'hFF);
    ahb(1, cnt_addr, cnt);
    ahb(1, 32'h204, {24'h0, en});
    seen = 0;
  endtask

  // Expected trap status for one monitored cycle
  function automatic logic [31:0] exp_trap(logic [2:0] g, logic [1:0] m, logic io, logic [15:0] a);
    logic s1, s2, kb, ps;
    s1 = a[15:3] == 13'h7F;
    s2 = a[15:3] == 13'h5F;
    kb = a == 16'h0060 || a == 16'h0064 || (m[1] && (m[0] ? s2 : s1));
    ps = a[15:3] == 13'h6F || a[15:3] == 13'h4F || (s1 && m != 2'b10) || (s2 && m != 2'b11);
    return (io && g[2] && g[0]) ? {28'h0, kb, ps, 2'b00} : 32'h0;
  endfunction

  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 0;
    foreach (bases[i]) rd(32'h200 + 4 * (i % 5), 32'h0);
    rd(32'h278, 32'h0);
    ahb(1, 32'h278, 32'hA5C3);
    rd(32'h278, 32'hA5C3);
    rd(32'h3FC, 32'h0);
    for (int g = 1; g < 4; g++) begin
      ahb(1, 32'h200, g);
      n0 = susp_n;
      ahb(1, 32'h2B8, 0);
      repeat (3) @(posedge sys_clk);
      chk(susp_n - n0, g == 3);
    end
    ahb(1, 32'h208, 32'h0C);
    repeat (40) begin
      r = $random(seed);
      k = r[10:8] % 7;
      e = exp_trap(r[2:0], r[4:3], r[5] | r[6], bases[k] + ((k > 1 && k < 6) ? r[13:11] : 0));
      ahb(1, 32'h200, r[2:0]);
      ahb(1, 32'h24C, r[4:3]);
      hit(r[5] | r[6], {r[31:16], bases[k] + ((k > 1 && k < 6) ? 16'(r[13:11]) : 16'h0)});
      rd(32'h218, e);
      chk(smi, e != 0);
      ahb(1, 32'h218, 32'hFF);
    end
    ahb(1, 32'h208, 0);
    ahb(1, 32'h24C, 0);
    ahb(1, 32'h200, 32'h03);
    rearm(32'h278, 2, 8'h08);
    watch(7);
    chk(seen, 0);
    watch(20);
    chk(seen, 1);
    rd(32'h214, 32'h08);
    rd(32'h320, 32'h01);
    ahb(1, 32'h200, 32'h01);
    rearm(32'h278, 2, 8'h08);
    watch(40);
    chk(seen, 0);
    ahb(1, 32'h278, 32'hFFFF);
    ahb(1, 32'h200, 32'h03);
    watch(24);
    chk(seen, 1);
    ahb(1, 32'h200, 32'h02);
    rearm(32'h278, 2, 8'h08);
    watch(40);
    chk(seen, 0);
    ahb(1, 32'h200, 32'h03);
    rearm(32'h278, 1, 8'h08);
    watch(60);
    chk(seen, 0);
    rearm(32'h278, 3, 8'h08);
    repeat (10) begin
      hit(1, 32'h0064);
      watch(2);
    end
    chk(seen, 0);
    watch(40);
    chk(seen, 1);
    ahb(1, 32'h24C, 32'h03);
    rearm(32'h270, 3, 8'h04);
    repeat (10) begin
      hit(1, 32'h02F8);
      watch(2);
    end
    chk(seen, 1);
    rd(32'h214, 32'h04);
    // Software swaps timer for trap after power down
    ahb(1, 32'h204, 0);
    ahb(1, 32'h208, 32'h08);
    ahb(1, 32'h200, 32'h07);
    ahb(1, 32'h214, 32'hFF);
    hit(1, 32'h0060);
    rd(32'h218, 32'h08);
    test_done;
  end
endmodule // test_peripheral_idle_timers_traps
